// *** logic/anr_defines.vh ***
`ifndef ANR_DEFINES_VH
`define ANR_DEFINES_VH

// ----------------------------------------
// Register indexes, byte address is 4x
// ----------------------------------------
`define ANR_IDX_EXPANSION   6'h06
`define ANR_IDX_NP_TX       6'h07
`define ANR_IDX_NP_RX       6'h08
`define ANR_IDX_MS_STATUS   6'h0a
`define ANR_IDX_CONTROL     6'h10
`define ANR_IDX_IRQ_STATUS  6'h11
`define ANR_IDX_IRQ_ENABLE  6'h12
`define ANR_IDX_IRQ_CLEAR   6'h13

// ----------------------------------------
// Expansion status fields
// ----------------------------------------
`define ANR_EXP_PD_FAULT    4
`define ANR_EXP_LP_NP_ABLE  3
`define ANR_EXP_LOC_NP_ABLE 2
`define ANR_EXP_PAGE_RX     1
`define ANR_EXP_LP_AN_ABLE  0
`define ANR_LOCAL_NP_ABLE   1'b1

// ----------------------------------------
// Next page fields
// ----------------------------------------
`define ANR_NP_NEXT         15
`define ANR_NP_MSG_SEL      13
`define ANR_NP_SECOND_ACKNOWLEDGE         12
`define ANR_NP_TOGGLE       11
`define ANR_NP_CODE_HI      10
`define ANR_NP_TX_CODE_RST  11'h001
`define ANR_NP_TX_WR_MASK   16'hb7ff

// ----------------------------------------
// Master/slave status fields
// ----------------------------------------
`define ANR_MS_FAULT        15
`define ANR_MS_MASTER       14
`define ANR_MS_LOCAL_RX_OK  13
`define ANR_MS_REMOTE_RX_OK 12
`define ANR_MS_GIG_FD_ADV   11
`define ANR_MS_LP_GIG_HD    10
`define ANR_IDLE_MAX        8'hff

// ----------------------------------------
// Own control and interrupt layout
// ----------------------------------------
`define ANR_CTL_AN_ENABLE   0
`define ANR_CTL_RESET       16'h0001
`define ANR_IRQ_PD_FAULT    0
`define ANR_IRQ_PAGE_RX     1
`define ANR_IRQ_MS_FAULT    2
`define ANR_IRQ_IDLE_ERR    3
`define ANR_IRQ_BITS        4

`endif

// *** logic/anr_sticky_flag.v ***
`timescale 1ns/1ps
// ----------------------------------------
// Sticky flag, set wins over clear
// ----------------------------------------
module anr_sticky_flag (
    input  wire ref_clk_in,
    input  wire rst_in,
    input  wire set_in,
    input  wire clr_in,
    output wire flag_out
);
    reg flag_reg;
    reg flag_next;

    always @* begin
        flag_next = flag_reg;
        if (clr_in) begin
            flag_next = 1'b0;
        end
        // A set in the clearing cycle must not be lost
        if (set_in) begin
            flag_next = 1'b1;
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            flag_reg <= 1'b0;
        end else begin
            flag_reg <= flag_next;
        end
    end

    assign flag_out = flag_reg;
endmodule // anr_sticky_flag

// *** logic/anr_idle_counter.v ***
`timescale 1ns/1ps
`include "anr_defines.vh"
// ----------------------------------------
// Idle error counter, restart on read
// ----------------------------------------
module anr_idle_counter (
    input  wire       ref_clk_in,
    input  wire       rst_in,
    input  wire       inc_in,
    input  wire       restart_in,
    output wire [7:0] count_out
);
    reg [7:0] count_reg;
    reg [7:0] count_next;

    always @* begin
        count_next = count_reg;
        if (restart_in) begin
            // Error in the read cycle counts for the next read
            count_next = {7'h00, inc_in};
        end else if (inc_in && count_reg != `ANR_IDLE_MAX) begin
            count_next = count_reg + 8'h01;
        end
    end

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_reg <= 8'h00;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count_out = count_reg;
endmodule // anr_idle_counter

// *** logic/anr_regs.v ***
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "anr_defines.vh"
module anr_regs (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [7:0]  paddr_in,
    input  wire [31:0] pwdata_in,
    output wire [31:0] prdata_out,
    output wire        pready_out,
    output wire        pslverr_out,
    output wire        irq_out,
    input  wire        pd_fault_in,
    input  wire        partner_np_able_in,
    input  wire        partner_autoneg_able_in,
    input  wire        page_rx_in,
    input  wire [15:0] page_rx_word_in,
    input  wire        page_sent_in,
    input  wire        ms_fault_in,
    input  wire        ms_master_in,
    input  wire        local_rx_ok_in,
    input  wire        remote_rx_ok_in,
    input  wire        gig_fd_adv_in,
    input  wire        partner_gig_hd_in,
    input  wire        idle_err_in,
    output wire        an_enable_out,
    output wire [15:0] np_tx_word_out,
    output wire        tx_more_pages_out,
    output wire        tx_message_page_out,
    output wire [10:0] tx_message_code_out,
    output wire [10:0] tx_unformatted_code_out,
    output wire        rx_message_page_out,
    output wire [10:0] rx_message_code_out,
    output wire [10:0] rx_unformatted_code_out,
    output wire        rx_partner_complies_out
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire       setup_rd;
    wire       wr_done;
    wire [5:0] idx;
    wire       aligned;
    reg        hit_exp;
    reg        hit_np_tx;
    reg        hit_np_rx;
    reg        hit_ms;
    reg        hit_ctl;
    reg        hit_ist;
    reg        hit_ien;
    reg        hit_icl;
    reg        mapped;

    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    reg        pready_reg;
    reg        pslverr_reg;
    reg        irq_reg;

    assign idx     = paddr_in[7:2];
    assign aligned = (paddr_in[1:0] == 2'b00);
    // Read side effects act at the setup edge, where the data is caught
    assign setup_rd = psel_in && !penable_in && !pwrite_in;
    assign wr_done  = psel_in && penable_in && pready_reg && pwrite_in;

    always @* begin
        hit_exp   = 1'b0;
        hit_np_tx = 1'b0;
        hit_np_rx = 1'b0;
        hit_ms    = 1'b0;
        hit_ctl   = 1'b0;
        hit_ist   = 1'b0;
        hit_ien   = 1'b0;
        hit_icl   = 1'b0;
        if (!aligned) begin
            hit_exp = 1'b0;
        end else if (idx == `ANR_IDX_EXPANSION) begin
            hit_exp = 1'b1;
        end else if (idx == `ANR_IDX_NP_TX) begin
            hit_np_tx = 1'b1;
        end else if (idx == `ANR_IDX_NP_RX) begin
            hit_np_rx = 1'b1;
        end else if (idx == `ANR_IDX_MS_STATUS) begin
            hit_ms = 1'b1;
        end else if (idx == `ANR_IDX_CONTROL) begin
            hit_ctl = 1'b1;
        end else if (idx == `ANR_IDX_IRQ_STATUS) begin
            hit_ist = 1'b1;
        end else if (idx == `ANR_IDX_IRQ_ENABLE) begin
            hit_ien = 1'b1;
        end else if (idx == `ANR_IDX_IRQ_CLEAR) begin
            hit_icl = 1'b1;
        end
        mapped = hit_exp | hit_np_tx | hit_np_rx | hit_ms
               | hit_ctl | hit_ist | hit_ien | hit_icl;
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    reg [15:0] ctl_reg;
    reg [15:0] np_tx_reg;
    reg        toggle_reg;
    reg [15:0] np_rx_reg;
    reg [`ANR_IRQ_BITS-1:0] ien_reg;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            ctl_reg   <= `ANR_CTL_RESET;
            np_tx_reg <= {5'h00, `ANR_NP_TX_CODE_RST};
            ien_reg   <= {`ANR_IRQ_BITS{1'b0}};
        end else if (wr_done) begin
            if (hit_ctl) begin
                ctl_reg <= {15'h0000, pwdata_in[`ANR_CTL_AN_ENABLE]};
            end
            if (hit_np_tx) begin
                // Next page, type, second_acknowledge, code writable
                np_tx_reg <= pwdata_in[15:0] & `ANR_NP_TX_WR_MASK;
            end
            if (hit_ien) begin
                ien_reg <= pwdata_in[`ANR_IRQ_BITS-1:0];
            end
        end
    end

    // ----------------------------------------
    // Toggle and received page
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            toggle_reg <= 1'b0;
            np_rx_reg  <= 16'h0000;
        end else begin
            if (page_sent_in) begin
                // Next word carries the inverse of the one just exchanged
                toggle_reg <= ~toggle_reg;
            end
            if (page_rx_in) begin
                np_rx_reg <= page_rx_word_in & 16'hbfff;
            end
        end
    end

    // ----------------------------------------
    // Sticky event flags
    // ----------------------------------------
    wire pd_fault_flag;
    wire page_rx_flag;
    wire ms_fault_flag;
    wire [7:0] idle_count;
    wire rd_exp;
    wire rd_ms;

    assign rd_exp = setup_rd && hit_exp;
    assign rd_ms  = setup_rd && hit_ms;

    anr_sticky_flag u_pd_fault (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (pd_fault_in),
        .clr_in     (rd_exp),
        .flag_out   (pd_fault_flag)
    );

    anr_sticky_flag u_page_rx (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (page_rx_in),
        .clr_in     (rd_exp),
        .flag_out   (page_rx_flag)
    );

    anr_sticky_flag u_ms_fault (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .set_in     (ms_fault_in),
        .clr_in     (rd_ms),
        .flag_out   (ms_fault_flag)
    );

    anr_idle_counter u_idle (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .inc_in     (idle_err_in),
        .restart_in (rd_ms),
        .count_out  (idle_count)
    );

    // ----------------------------------------
    // Interrupt status, clear and line
    // ----------------------------------------
    wire [`ANR_IRQ_BITS-1:0] irq_set;
    wire [`ANR_IRQ_BITS-1:0] irq_clr;
    wire [`ANR_IRQ_BITS-1:0] ist;

    assign irq_set[`ANR_IRQ_PD_FAULT] = pd_fault_in;
    assign irq_set[`ANR_IRQ_PAGE_RX]  = page_rx_in;
    assign irq_set[`ANR_IRQ_MS_FAULT] = ms_fault_in;
    assign irq_set[`ANR_IRQ_IDLE_ERR] = idle_err_in;

    genvar g;
    generate
        for (g = 0; g < `ANR_IRQ_BITS; g = g + 1) begin : g_irq
            assign irq_clr[g] = wr_done && hit_icl && pwdata_in[g];
            anr_sticky_flag u_flag (
                .ref_clk_in (ref_clk_in),
                .rst_in     (rst_in),
                .set_in     (irq_set[g]),
                .clr_in     (irq_clr[g]),
                .flag_out   (ist[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Register views
    // ----------------------------------------
    reg [15:0] exp_view;
    reg [15:0] np_tx_view;
    reg [15:0] ms_view;

    always @* begin
        exp_view = 16'h0000;
        exp_view[`ANR_EXP_PD_FAULT]    = pd_fault_flag;
        exp_view[`ANR_EXP_LP_NP_ABLE]  = partner_np_able_in;
        exp_view[`ANR_EXP_LOC_NP_ABLE] = `ANR_LOCAL_NP_ABLE;
        exp_view[`ANR_EXP_PAGE_RX]     = page_rx_flag;
        // Only meaningful while negotiation runs, else held low
        exp_view[`ANR_EXP_LP_AN_ABLE]  = partner_autoneg_able_in
                                       & ctl_reg[`ANR_CTL_AN_ENABLE];

        np_tx_view = np_tx_reg;
        np_tx_view[`ANR_NP_TOGGLE] = toggle_reg;

        ms_view = {8'h00, idle_count};
        ms_view[`ANR_MS_FAULT]        = ms_fault_flag;
        ms_view[`ANR_MS_MASTER]       = ms_master_in;
        ms_view[`ANR_MS_LOCAL_RX_OK]  = local_rx_ok_in;
        ms_view[`ANR_MS_REMOTE_RX_OK] = remote_rx_ok_in;
        ms_view[`ANR_MS_GIG_FD_ADV]   = gig_fd_adv_in;
        ms_view[`ANR_MS_LP_GIG_HD]    = partner_gig_hd_in;
    end

    always @* begin
        prdata_next = 32'h0000_0000;
        if (hit_exp) begin
            prdata_next = {16'h0000, exp_view};
        end else if (hit_np_tx) begin
            prdata_next = {16'h0000, np_tx_view};
        end else if (hit_np_rx) begin
            prdata_next = {16'h0000, np_rx_reg};
        end else if (hit_ms) begin
            prdata_next = {16'h0000, ms_view};
        end else if (hit_ctl) begin
            prdata_next = {16'h0000, ctl_reg};
        end else if (hit_ist) begin
            prdata_next = {28'h000_0000, ist};
        end else if (hit_ien) begin
            prdata_next = {28'h000_0000, ien_reg};
        end
    end

    // ----------------------------------------
    // Bus answer, no wait state
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            // Data and error are fixed at setup, shown in access phase
            pready_reg <= psel_in && !penable_in;
            if (psel_in && !penable_in) begin
                prdata_reg  <= pwrite_in ? 32'h0000_0000 : prdata_next;
                pslverr_reg <= !mapped;
            end else if (!psel_in) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Outputs toward the negotiation engine
    // ----------------------------------------
    reg        an_en_reg;
    reg [15:0] np_word_reg;
    reg        tx_more_reg;
    reg        tx_msg_reg;
    reg [10:0] tx_mcode_reg;
    reg [10:0] tx_ucode_reg;
    reg        rx_msg_reg;
    reg [10:0] rx_mcode_reg;
    reg [10:0] rx_ucode_reg;
    reg        rx_second_acknowledge_reg;

    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_reg      <= 1'b0;
            an_en_reg    <= 1'b0;
            np_word_reg  <= 16'h0000;
            tx_more_reg  <= 1'b0;
            tx_msg_reg   <= 1'b0;
            tx_mcode_reg <= 11'h000;
            tx_ucode_reg <= 11'h000;
            rx_msg_reg   <= 1'b0;
            rx_mcode_reg <= 11'h000;
            rx_ucode_reg <= 11'h000;
            rx_second_acknowledge_reg  <= 1'b0;
        end else begin
            irq_reg     <= |(ist & ien_reg);
            an_en_reg   <= ctl_reg[`ANR_CTL_AN_ENABLE];
            np_word_reg <= np_tx_view;
            tx_more_reg <= np_tx_reg[`ANR_NP_NEXT];
            tx_msg_reg  <= np_tx_reg[`ANR_NP_MSG_SEL];
            // Code goes to the field that matches the page type
            if (np_tx_reg[`ANR_NP_MSG_SEL]) begin
                tx_mcode_reg <= np_tx_reg[`ANR_NP_CODE_HI:0];
                tx_ucode_reg <= 11'h000;
            end else begin
                tx_mcode_reg <= 11'h000;
                tx_ucode_reg <= np_tx_reg[`ANR_NP_CODE_HI:0];
            end
            rx_msg_reg  <= np_rx_reg[`ANR_NP_MSG_SEL];
            rx_second_acknowledge_reg <= np_rx_reg[`ANR_NP_SECOND_ACKNOWLEDGE];
            if (np_rx_reg[`ANR_NP_MSG_SEL]) begin
                rx_mcode_reg <= np_rx_reg[`ANR_NP_CODE_HI:0];
                rx_ucode_reg <= 11'h000;
            end else begin
                rx_mcode_reg <= 11'h000;
                rx_ucode_reg <= np_rx_reg[`ANR_NP_CODE_HI:0];
            end
        end
    end

    assign prdata_out              = prdata_reg;
    assign pready_out              = pready_reg;
    assign pslverr_out             = pslverr_reg;
    assign irq_out                 = irq_reg;
    assign an_enable_out           = an_en_reg;
    assign np_tx_word_out          = np_word_reg;
    assign tx_more_pages_out       = tx_more_reg;
    assign tx_message_page_out     = tx_msg_reg;
    assign tx_message_code_out     = tx_mcode_reg;
    assign tx_unformatted_code_out = tx_ucode_reg;
    assign rx_message_page_out     = rx_msg_reg;
    assign rx_message_code_out     = rx_mcode_reg;
    assign rx_unformatted_code_out = rx_ucode_reg;
    assign rx_partner_complies_out = rx_second_acknowledge_reg;
endmodule // anr_regs

// *** bench/anr_regs_asserts.sv ***
`timescale 1ns/1ps
`include "anr_defines.vh"
// ----------------------------------------
// Port checks for the register bank
// ----------------------------------------
module anr_regs_asserts (
    input wire        ref_clk_in,
    input wire        rst_in,
    input wire        psel_in,
    input wire        penable_in,
    input wire [7:0]  paddr_in,
    input wire [31:0] prdata_out,
    input wire        pready_out,
    input wire        pslverr_out,
    input wire        irq_out,
    input wire        page_rx_in,
    input wire [15:0] page_rx_word_in,
    input wire        page_sent_in,
    input wire [15:0] np_tx_word_out,
    input wire        tx_message_page_out,
    input wire [10:0] tx_unformatted_code_out,
    input wire        rx_partner_complies_out
);
    wire       setup = psel_in && !penable_in;
    wire [5:0] idx   = paddr_in[7:2];
    wire       hit   = (paddr_in[1:0] == 2'b00) && (idx inside {`ANR_IDX_EXPANSION,
                       `ANR_IDX_NP_TX, `ANR_IDX_NP_RX, `ANR_IDX_MS_STATUS, `ANR_IDX_CONTROL,
                       `ANR_IDX_IRQ_STATUS, `ANR_IDX_IRQ_ENABLE, `ANR_IDX_IRQ_CLEAR});
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    a_ready_follows: assert property (setup |=> pready_out)
        else $error("ready missing after setup");
    a_ready_single: assert property (pready_out |=> !pready_out)
        else $error("ready held too long");
    a_ready_cause: assert property (pready_out |-> $past(setup))
        else $error("ready without setup");
    a_err_unmapped: assert property (setup && !hit |=> pslverr_out && prdata_out == 0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && hit |=> !pslverr_out)
        else $error("mapped access refused");
    a_upper_zero: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_tx_split: assert property (tx_message_page_out |-> tx_unformatted_code_out == 0)
        else $error("unformatted code shown on message page");
    a_rx_second_acknowledge: assert property (page_rx_in |=> ##1
        rx_partner_complies_out == $past(page_rx_word_in[12], 2))
        else $error("received acknowledge wrong");
    a_toggle_flip: assert property (page_sent_in && !$past(page_sent_in) ##1
        !page_sent_in |=> np_tx_word_out[11] != $past(np_tx_word_out[11], 2))
        else $error("toggle did not invert");
    a_reset_quiet: assert property (disable iff (1'b0) rst_in |=> !irq_out && !pready_out)
        else $error("outputs active in reset");
    cover property (setup && !hit ##1 pslverr_out);
    cover property (!irq_out ##1 irq_out);
    cover property (page_rx_in ##2 rx_partner_complies_out);
endmodule // anr_regs_asserts

// *** bench/anr_regs_bench.sv ***
`timescale 1ns/1ps
`include "anr_defines.vh"
// ----------------------------------------
// Bench for the register bank
// ----------------------------------------
module anr_regs_bench;
    localparam [7:0] A_EXP = {`ANR_IDX_EXPANSION, 2'b00};
    localparam [7:0] A_TX  = {`ANR_IDX_NP_TX, 2'b00};
    localparam [7:0] A_RX  = {`ANR_IDX_NP_RX, 2'b00};
    localparam [7:0] A_MS  = {`ANR_IDX_MS_STATUS, 2'b00};
    localparam [7:0] A_CTL = {`ANR_IDX_CONTROL, 2'b00};
    localparam [7:0] A_IST = {`ANR_IDX_IRQ_STATUS, 2'b00};
    localparam [7:0] A_IEN = {`ANR_IDX_IRQ_ENABLE, 2'b00};
    localparam [7:0] A_ICL = {`ANR_IDX_IRQ_CLEAR, 2'b00};
    reg         clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwd = 32'h0, d, r;
    reg  [15:0] pw = 16'h0, x;
    reg  [4:0]  ev = 5'h0, lv = 5'h0;
    reg         npa = 1'b0, ana = 1'b1, e;
    wire [31:0] prd;
    wire        prdy, perr, irq, an_en, tx_more, tx_msg, rx_msg, rx_ack;
    wire [15:0] tx_w;
    wire [10:0] tx_mc, tx_uc, rx_mc, rx_uc;
    integer     n_mismatch = 0, tests_run = 0, seed = 2, cyc = 0, i, n, tog = 0;

    anr_regs u_dut (
        .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(paddr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .irq_out(irq), .pd_fault_in(ev[0]), .partner_np_able_in(npa),
        .partner_autoneg_able_in(ana), .page_rx_in(ev[1]), .page_rx_word_in(pw),
        .page_sent_in(ev[2]), .ms_fault_in(ev[3]), .ms_master_in(lv[4]),
        .local_rx_ok_in(lv[3]), .remote_rx_ok_in(lv[2]), .gig_fd_adv_in(lv[1]),
        .partner_gig_hd_in(lv[0]), .idle_err_in(ev[4]), .an_enable_out(an_en),
        .np_tx_word_out(tx_w), .tx_more_pages_out(tx_more), .tx_message_page_out(tx_msg),
        .tx_message_code_out(tx_mc), .tx_unformatted_code_out(tx_uc),
        .rx_message_page_out(rx_msg), .rx_message_code_out(rx_mc),
        .rx_unformatted_code_out(rx_uc), .rx_partner_complies_out(rx_ack));

    always #20 clk = ~clk;

    // ----------------------------------------
    // Reference model of the read-sensitive fields
    // ----------------------------------------
    reg  [31:0] m_rd = 32'h0;
    reg         m_an = 1'b1;
    integer     m_pd = 0, m_pg = 0, m_msf = 0, m_idle = 0;
    wire        rd_e = psel && !pen && !pwr && paddr == A_EXP;
    wire        rd_m = psel && !pen && !pwr && paddr == A_MS;

    // Expected read word is taken at the setup edge, before the read clears it
    always @(posedge clk) begin
        if (rst) begin
            m_pd   <= 0;
            m_pg   <= 0;
            m_msf  <= 0;
            m_idle <= 0;
            m_an   <= 1'b1;
        end else begin
            if (psel && pen && pwr && prdy && paddr == A_CTL)
                m_an <= pwd[0];
            if (rd_e)
                m_rd <= {27'h0, m_pd[0], npa, 1'b1, m_pg[0], ana & m_an};
            if (rd_m)
                m_rd <= {16'h0, m_msf[0], lv, 2'b00, m_idle[7:0]};
            // A set in the clearing cycle wins, as in the flags
            m_pd  <= ev[0] | (m_pd[0] & !rd_e);
            m_pg  <= ev[1] | (m_pg[0] & !rd_e);
            m_msf <= ev[3] | (m_msf[0] & !rd_m);
            if (rd_m)
                m_idle <= ev[4];
            else if (ev[4] && m_idle < 255)
                m_idle <= m_idle + 1;
        end
    end

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end

    task test_done;
        begin
            if (n_mismatch == 0 && tests_run > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // Expected page type and code split, from bit 13 alone
    function [22:0] code_split(input [15:0] w);
        begin
            code_split = {w[13], w[13] ? {w[10:0], 11'h000} : {11'h000, w[10:0]}};
        end
    endfunction

    // Request held until pready is sampled high; data taken at that edge
    task apb(input [7:0] a, input wr, input [31:0] wd);
        begin
            @(posedge clk);
            psel <= 1'b1; pen <= 1'b0; paddr <= a; pwr <= wr; pwd <= wd;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (prdy !== 1'b1) @(posedge clk);
            d = prd;
            e = perr;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask

    task rd(input [7:0] a, input [31:0] exp, input string nm);
        begin
            apb(a, 1'b0, 32'h0);
            chk(nm, d, exp);
            if (a == A_EXP || a == A_MS)
                chk({nm, "_model"}, d, m_rd);
        end
    endtask

    // Event inputs held high for k cycles
    task fire(input [4:0] v, input integer k);
        begin
            @(posedge clk) ev <= v;
            repeat (k) @(posedge clk);
            ev <= 5'h0;
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(A_EXP, 32'h0000_0005, "exp_rst");
        rd(A_TX, 32'h0000_0001, "tx_rst");
        rd(A_RX, 32'h0000_0000, "rx_rst");
        rd(A_MS, 32'h0000_0000, "ms_rst");
        npa <= 1'b1;
        rd(A_EXP, 32'h0000_000d, "exp_np");
        ana <= 1'b0;
        rd(A_EXP, 32'h0000_000c, "exp_lp_off");
        ana <= 1'b1;
        apb(A_CTL, 1'b1, 32'h0);
        rd(A_EXP, 32'h0000_000c, "exp_an_off");
        chk("an_en", an_en, 0);
        apb(A_CTL, 1'b1, 32'h1);
        r = $random(seed);
        pw <= r[15:0];
        fire(5'h03, 1);
        rd(A_EXP, 32'h0000_001f, "exp_set");
        rd(A_EXP, 32'h0000_000d, "exp_rc");
        x = r[15:0] & 16'hbfff;
        rd(A_RX, {16'h0, x}, "rx_page");
        apb(A_RX, 1'b1, ~r);
        rd(A_RX, {16'h0, x}, "rx_ro");
        chk("rx_sel", {rx_msg, rx_mc, rx_uc}, code_split(x));
        chk("rx_second_acknowledge", rx_ack, x[12]);
        pw <= x ^ 16'h2000;
        fire(5'h02, 1);
        x = x ^ 16'h2000;
        rd(A_RX, {16'h0, x}, "rx_page2");
        chk("rx_sel2", {rx_msg, rx_mc, rx_uc}, code_split(x));
        for (i = 0; i < 4; i = i + 1) begin
            r = $random(seed);
            r[13] = i[0];
            apb(A_TX, 1'b1, r);
            x = (r[15:0] & 16'hb7ff) | {4'h0, tog[0], 11'h0};
            rd(A_TX, {16'h0, x}, "tx_word");
            chk("tx_out", tx_w, x);
            chk("tx_bits", {tx_more, tx_msg, tx_mc, tx_uc}, {x[15], code_split(x)});
            fire(5'h04, 1);
            tog = tog ^ 1;
        end
        r = $random(seed);
        lv <= r[4:0];
        n = 1 + r[10:5];
        fire(5'h08, 1);
        fire(5'h10, n);
        rd(A_MS, {16'h0, 1'b1, r[4:0], 2'b00, n[7:0]}, "ms_set");
        chk("ms_role", d[14], lv[4]);
        chk("ms_rx_ok", d[13:12], lv[3:2]);
        chk("ms_gig", d[11:10], lv[1:0]);
        rd(A_MS, {16'h0, 1'b0, r[4:0], 10'h0}, "ms_clr");
        fire(5'h10, 300);
        rd(A_MS, {16'h0, 1'b0, r[4:0], 2'b00, 8'hff}, "ms_sat");
        apb(A_ICL, 1'b1, 32'h0000_000f);
        rd(A_IST, 32'h0000_0000, "irq_clr");
        apb(A_IEN, 1'b1, 32'h0000_0002);
        fire(5'h01, 1);
        repeat (3) @(posedge clk);
        chk("irq_mask", irq, 0);
        rd(A_IST, 32'h0000_0001, "irq_st");
        apb(A_IEN, 1'b1, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq_on", irq, 1);
        apb(A_ICL, 1'b1, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("irq_off", irq, 0);
        rd(A_ICL, 32'h0000_0000, "irq_wo");
        rd(8'h04, 32'h0000_0000, "unmapped");
        chk("unmapped_err", e, 1);
        rd(8'h19, 32'h0000_0000, "unaligned");
        chk("unaligned_err", e, 1);
        test_done;
    end
endmodule // anr_regs_bench

bind anr_regs anr_regs_asserts u_chk (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
    .paddr_in(paddr_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .irq_out(irq_out), .page_rx_in(page_rx_in),
    .page_rx_word_in(page_rx_word_in), .page_sent_in(page_sent_in),
    .np_tx_word_out(np_tx_word_out), .tx_message_page_out(tx_message_page_out),
    .tx_unformatted_code_out(tx_unformatted_code_out),
    .rx_partner_complies_out(rx_partner_complies_out));
